// [pkg/tsc_pkg.sv]
/*
  Package for the transmit statistics counter bank: register map, frame
  length bin limits, bus response codes and the event carrier structs.
  Assumes a 32-bit AXI4-Lite register bus and a transmit datapath on the
  same clock that reports one frame per cycle at most.
*/
package tsc_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [15:0] TSC_ADDR_65_127 = 16'h40DC;
  localparam logic [15:0] TSC_ADDR_128_255 = 16'h40E0;
  localparam logic [15:0] TSC_ADDR_256_511 = 16'h40E4;
  localparam logic [15:0] TSC_ADDR_512_1023 = 16'h40E8;
  localparam logic [15:0] TSC_ADDR_1024_UP = 16'h40EC;
  localparam logic [15:0] TSC_ADDR_MCAST = 16'h40F0;
  localparam logic [15:0] TSC_ADDR_BCAST = 16'h40F4;
  localparam logic [15:0] TSC_ADDR_CTX_DONE = 16'h40F8;
  localparam logic [15:0] TSC_ADDR_CTX_FAIL = 16'h40FC;
  localparam logic [15:0] TSC_ADDR_CTRL = 16'h4100;

  localparam int TSC_NCNT = 9;
  localparam int TSC_NBIN = 5;
  localparam logic [31:0] TSC_CNT_RESET = 32'h0000_0000;

  // Counter indices
  localparam int TSC_IDX_MCAST = 5;
  localparam int TSC_IDX_BCAST = 6;
  localparam int TSC_IDX_DONE = 7;
  localparam int TSC_IDX_FAIL = 8;

  // Control register bits
  localparam int TSC_CTRL_TX_EN = 0;
  localparam int TSC_CTRL_TSO_EN = 1;
  localparam logic [1:0] TSC_CTRL_RESET = 2'h0;

  // ------------------------------------------------------------
  // Frame length bin lower bounds (destination address through CRC)
  // ------------------------------------------------------------
  localparam logic [15:0] TSC_LEN_B0 = 16'h0041;
  localparam logic [15:0] TSC_LEN_B1 = 16'h0080;
  localparam logic [15:0] TSC_LEN_B2 = 16'h0100;
  localparam logic [15:0] TSC_LEN_B3 = 16'h0200;
  localparam logic [15:0] TSC_LEN_B4 = 16'h0400;

  localparam logic [1:0] TSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TSC_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic        done;       // Frame fully sent, one-cycle pulse
    logic [15:0] len;        // Bytes, destination address through CRC
    logic        partial;    // Cut short by half-duplex collision
    logic        mcast;
    logic        bcast;
    logic        flow_ctrl;  // Pause frame
  } tsc_frame_t;

  typedef struct packed {
    logic       ctx_start;   // New offload context begins
    logic       ctx_last;    // Last segment of context loaded to buffer
    logic       ctx_fail;    // Excessive collisions on a context segment
    logic       len_err;     // Context payload length error
  } tsc_ctx_t;

endpackage

// [src/tsc_counters.sv]
/*
  Transmit statistics counter bank: five frame-size bins, multicast,
  broadcast, offload contexts done and failed, all read-only over
  AXI4-Lite, plus one control register holding the enables.
  Assumes frame and context events come from logic on sys_clk.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Operation
// R1: Count completed frames of 65 to 127 bytes in the first bin.
// R2: Count completed frames of 128 to 255 bytes in the second bin.
// R3: Count completed frames of 256 to 511 bytes in the third bin.
// R4: Count completed frames of 512 to 1023 bytes in the fourth bin.
// R5: Count completed frames of 1024 bytes or more in the largest bin.
// R6: Largest bin includes 1522-byte tagged frames.
// R7: Bins skip partial frames cut short by half-duplex collisions.
// R8: No counter moves while transmit is disabled.
// R9: Bins count frames of every origin alike.
// R10: Count multicast destination frames, clear or secured.
// R11: Multicast count excludes flow-control frames.
// R12: Count broadcast destination frames, clear or secured.
// R13: Count one offload context when its last segment enters the buffer.
// R14: Context count moves only with transmit and offload both enabled.
// R15: A failed context counts as at most one failure.
// R16: Excessive collisions or payload length errors fail the context.
// R17: No indication of how much failed context data went out.
// R18: Each counter is 32 bits wide and starts at zero.
// R19: Each completed frame of 65 bytes or more hits exactly one bin.
module tsc_counters (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire tsc_pkg::tsc_frame_t frame_ev,
  input wire tsc_pkg::tsc_ctx_t ctx_ev,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ------------------------------------------------------------
  // Enables and event decode
  // ------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic tx_en;
  logic tso_en;
  logic [tsc_pkg::TSC_NCNT-1:0] inc;
  logic [31:0] cnt_r [tsc_pkg::TSC_NCNT];
  logic ctx_failed_r;
  logic frame_ok;

  assign tx_en = ctrl_r[tsc_pkg::TSC_CTRL_TX_EN];
  assign tso_en = ctrl_r[tsc_pkg::TSC_CTRL_TSO_EN];
  // Origin is not an input at all, so every source is binned alike [R9]
  assign frame_ok = tx_en && frame_ev.done && !frame_ev.partial;  // [R7] [R8]

  // Bins are half-open ranges, so a frame of 65 bytes or more lands in exactly one [R19]
  assign inc[0] = frame_ok && frame_ev.len >= tsc_pkg::TSC_LEN_B0
                  && frame_ev.len < tsc_pkg::TSC_LEN_B1;  // [R1]
  assign inc[1] = frame_ok && frame_ev.len >= tsc_pkg::TSC_LEN_B1
                  && frame_ev.len < tsc_pkg::TSC_LEN_B2;  // [R2]
  assign inc[2] = frame_ok && frame_ev.len >= tsc_pkg::TSC_LEN_B2
                  && frame_ev.len < tsc_pkg::TSC_LEN_B3;  // [R3]
  assign inc[3] = frame_ok && frame_ev.len >= tsc_pkg::TSC_LEN_B3
                  && frame_ev.len < tsc_pkg::TSC_LEN_B4;  // [R4]
  // No upper limit, so 1522-byte tagged frames count here too
  assign inc[4] = frame_ok && frame_ev.len >= tsc_pkg::TSC_LEN_B4;  // [R5] [R6]

  assign inc[tsc_pkg::TSC_IDX_MCAST] = frame_ok && frame_ev.mcast
                                       && !frame_ev.flow_ctrl;  // [R10] [R11]
  assign inc[tsc_pkg::TSC_IDX_BCAST] = frame_ok && frame_ev.bcast;  // [R12]
  assign inc[tsc_pkg::TSC_IDX_DONE] = tx_en && tso_en && ctx_ev.ctx_last;  // [R13] [R14]
  // Only the first failure of a context counts; no byte tally is kept [R17]
  assign inc[tsc_pkg::TSC_IDX_FAIL] = tx_en && !ctx_failed_r
                                      && (ctx_ev.ctx_fail || ctx_ev.len_err);  // [R15] [R16]

  // ------------------------------------------------------------
  // Per-context failure latch
  // ------------------------------------------------------------
  // A fresh context clears the latch; a failure in that same cycle still sets it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctx_failed_r <= 1'b0;
    end else if (tx_en && (ctx_ev.ctx_fail || ctx_ev.len_err)) begin
      ctx_failed_r <= 1'b1;  // [R15]
    end else if (ctx_ev.ctx_start) begin
      ctx_failed_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------
  // Counters wrap at 32 bits; software reads differences
  for (genvar i = 0; i < tsc_pkg::TSC_NCNT; i++) begin : g_cnt
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        cnt_r[i] <= tsc_pkg::TSC_CNT_RESET;  // [R18]
      end else if (inc[i]) begin
        cnt_r[i] <= cnt_r[i] + 32'h0000_0001;  // [R18]
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  logic aw_hold_r;
  logic w_hold_r;
  logic [15:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;

  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 16'h0000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Counters are read-only; writes to them are dropped with OKAY
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= tsc_pkg::TSC_CTRL_RESET;
    end else if (do_write && awaddr_r[15:2] == tsc_pkg::TSC_ADDR_CTRL[15:2] && wstrb_r[0]) begin
      ctrl_r <= wdata_r[1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tsc_pkg::TSC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_r[15:2] >= tsc_pkg::TSC_ADDR_65_127[15:2]
                      && awaddr_r[15:2] <= tsc_pkg::TSC_ADDR_CTRL[15:2])
                     ? tsc_pkg::TSC_RESP_OKAY : tsc_pkg::TSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  logic [31:0] rd_val;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[15:2])
      tsc_pkg::TSC_ADDR_65_127[15:2]: rd_val = cnt_r[0];
      tsc_pkg::TSC_ADDR_128_255[15:2]: rd_val = cnt_r[1];
      tsc_pkg::TSC_ADDR_256_511[15:2]: rd_val = cnt_r[2];
      tsc_pkg::TSC_ADDR_512_1023[15:2]: rd_val = cnt_r[3];
      tsc_pkg::TSC_ADDR_1024_UP[15:2]: rd_val = cnt_r[4];
      tsc_pkg::TSC_ADDR_MCAST[15:2]: rd_val = cnt_r[tsc_pkg::TSC_IDX_MCAST];
      tsc_pkg::TSC_ADDR_BCAST[15:2]: rd_val = cnt_r[tsc_pkg::TSC_IDX_BCAST];
      tsc_pkg::TSC_ADDR_CTX_DONE[15:2]: rd_val = cnt_r[tsc_pkg::TSC_IDX_DONE];
      tsc_pkg::TSC_ADDR_CTX_FAIL[15:2]: rd_val = cnt_r[tsc_pkg::TSC_IDX_FAIL];
      tsc_pkg::TSC_ADDR_CTRL[15:2]: rd_val = {30'h0, ctrl_r};
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Address is taken with data in the same edge, so no read address holding
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tsc_pkg::TSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? tsc_pkg::TSC_RESP_OKAY : tsc_pkg::TSC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [tb/tsc_counters_properties.sv]
/*
  Checker for the register bus of the transmit statistics counter bank.
  Assumes it is bound to tsc_counters and sees that module's ports only.
*/
`timescale 1ns/1ps
module tsc_counters_chk (
  input wire logic sys_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Handshake steps
  // ------------------------------------------------------------
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  logic bad_a;
  assign bad_a = s_axi_araddr < tsc_pkg::TSC_ADDR_65_127 || s_axi_araddr > tsc_pkg::TSC_ADDR_CTRL;
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_bad_read: assert property (s_rd_take and bad_a |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_good_read: assert property (s_rd_take and !bad_a |=> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  chk_ctrl_upper: assert property (s_rd_take and s_axi_araddr == 16'h4100 |=> s_axi_rdata[31:2] == 30'h0)
    else $error("control upper bits set");
  chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  chk_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready longer than one cycle");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while one outstanding");
endmodule
bind tsc_counters tsc_counters_chk chk_u (.*);

// [tb/tb_tsc_counters.sv]
/*
  Testbench for the transmit statistics counter bank.
  Assumes the package and the counter module are compiled before it.
*/
`timescale 1ns/1ps
module tb_tsc_counters;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  tsc_pkg::tsc_frame_t frame_ev = '0;
  tsc_pkg::tsc_ctx_t ctx_ev = '0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] exp_c [9] = '{default: 32'h0};
  logic [31:0] d;
  logic ta, tw;
  int n_fail = 0;
  int samples_checked = 0;
  tsc_counters dut_u (.*);
  initial forever #5 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // Bus and event tasks
  // ------------------------------------------------------------
  task cmp(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  // Ready to take the answer is raised late on purpose, so the hold is exercised
  task rd(input logic [15:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] v);
    ta = 1'b0;
    tw = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge sys_clk);
      ta = ta | (s_axi_awready === 1'b1);
      tw = tw | (s_axi_wready === 1'b1);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // One event per edge; back-to-back calls give back-to-back events
  task fr(input logic [15:0] len, input logic [3:0] f);
    @(posedge sys_clk);
    frame_ev <= {1'b1, len, f};
    ctx_ev <= '0;
  endtask
  task cx(input logic [3:0] c);
    @(posedge sys_clk);
    ctx_ev <= c;
    frame_ev <= '0;
  endtask
  task chk_all();
    fr(16'h0, 4'h8);
    for (int i = 0; i < 9; i++) begin
      rd(tsc_pkg::TSC_ADDR_65_127 + 16'(4 * i));
      cmp(d, exp_c[i]);
      cmp({30'h0, r}, {30'h0, tsc_pkg::TSC_RESP_OKAY});
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset();
    chk_all();
    rd(16'h4104);
    cmp({d[31:2], r}, {30'h0, tsc_pkg::TSC_RESP_SLVERR});
    wr(tsc_pkg::TSC_ADDR_MCAST, 32'hFFFF_FFFF);
    chk_all();
  endtask
  task t_bins();
    logic [15:0] lens [12] = '{16'h40, 16'h41, 16'h7F, 16'h80, 16'hFF, 16'h100, 16'h1FF, 16'h200,
                               16'h3FF, 16'h400, 16'h5F2, 16'h64};
    wr(tsc_pkg::TSC_ADDR_CTRL, 32'h1);
    foreach (lens[k]) fr(lens[k], k == 11 ? 4'h8 : 4'h0);
    for (int i = 0; i < 5; i++) exp_c[i] = 32'h2;
    chk_all();
  endtask
  task t_cast();
    fr(16'h40, 4'h4);
    fr(16'h40, 4'h5);
    fr(16'h40, 4'h2);
    exp_c[5] = 32'h1;
    exp_c[6] = 32'h1;
    chk_all();
  endtask
  task t_ctx();
    logic [3:0] seq [8] = '{4'h8, 4'h4, 4'h8, 4'h2, 4'h2, 4'h1, 4'h8, 4'h1};
    cx(4'h8);
    cx(4'h4);
    chk_all();
    wr(tsc_pkg::TSC_ADDR_CTRL, 32'h3);
    rd(tsc_pkg::TSC_ADDR_CTRL);
    cmp(d, 32'h3);
    foreach (seq[k]) cx(seq[k]);
    exp_c[7] = 32'h1;
    exp_c[8] = 32'h2;
    chk_all();
  endtask
  task t_off();
    wr(tsc_pkg::TSC_ADDR_CTRL, 32'h2);
    fr(16'h100, 4'h6);
    cx(4'h8);
    cx(4'h4);
    cx(4'h1);
    chk_all();
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_bins();
    t_cast();
    t_ctx();
    t_off();
    conclude();
  end
  // Whole run is well under 2000 cycles; ten times that means a hang
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule
